// *** hdl/otp_prog_pkg.sv ***
// Purpose: constants for the one-time-programmable memory programmer
// Assumes: 40 MHz system clock (25 ns period)
// Notes: times are kept in their own units, cycle counts derived here
package otp_prog_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 15'h7fff;

  // Pulse width 95..105 us, aim at the nominal 100 us
  localparam int PULSE_MIN_US = 95;
  localparam int PULSE_MAX_US = 105;
  localparam int PULSE_NOM_US = 100;
  localparam int PULSE_CYC = (PULSE_NOM_US * 1000) / CLK_PERIOD_NS;

  // Setup and hold times, 2 us each, rounded up
  localparam int SETUP_US = 2;
  localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) /
                             CLK_PERIOD_NS;

  // Output valid 150 ns max, float 130 ns max: both waited out, rounded up
  localparam int OUT_VALID_NS = 150;
  localparam int OUT_FLOAT_NS = 130;
  localparam int OUT_VALID_CYC = (OUT_VALID_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int OUT_FLOAT_CYC = (OUT_FLOAT_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;

  // Reprogramming pulses allowed per byte after the first pass
  localparam logic [3:0] MAX_RETRY = 4'ha;

  localparam int TMR_W = 17;

  // Supply levels, encoded for the external switches
  localparam logic [1:0] SUP_OFF = 2'h0;
  localparam logic [1:0] SUP_NOM = 2'h1;
  localparam logic [1:0] SUP_PROG = 2'h2;
  localparam logic [1:0] SUP_ID = 2'h3;

  typedef enum logic [1:0] {
    OP_PROGRAM, OP_VERIFY, OP_READ_ID
  } op_t;

endpackage

// *** hdl/pin_sync.sv ***
// Purpose: two-flip-flop synchroniser for a bus of pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: only the second stage is used by others
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // Two stages, reset to zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pin_sync

// *** hdl/otp_programmer.sv ***
// Purpose: programmer for a 32K x 8 one-time-programmable memory
// Assumes: source bytes fetched one at a time by address
// Notes: supplies are driven as level codes to external switches
`timescale 1ns/1ps
// How it works
// - Each program pulse holds chip select low for 100 us, inside 95..105.
// - Address starts at zero, then core and program supplies are raised.
// - First pass gives each byte one pulse with no read back.
// - Second pass reads back and re-pulses up to ten times, reading each.
// - A byte still wrong after ten re-pulses ends the run as failed.
// - A verified byte moves on to the next address until all are done.
// - Supplies then switch off: the program supply sits at nominal for one cycle, then goes off, and no byte is read again before switching off.
// - Core supply goes up first and comes down last.
// - Reads wait out the output valid and output float delays.
// - Id mode raises the id pin; the low address bit picks maker or part.
module otp_programmer
  import otp_prog_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire op_t op,
  input wire logic [DATA_W-1:0] src_data,
  output logic [ADDR_W-1:0] src_addr,
  output logic [ADDR_W-1:0] rom_addr,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  output logic chip_sel_n,
  output logic out_drive_n,
  output logic [1:0] core_supply,
  output logic [1:0] prog_supply,
  output logic id_mode_address_pin,
  output logic busy,
  output logic done,
  output logic pass,
  output logic [DATA_W-1:0] maker_code,
  output logic [DATA_W-1:0] device_code
);

  // ********************************************************
  // Sequencer state
  // ********************************************************
  typedef enum {
    S_IDLE, S_VCC_UP, S_VPP_UP, S_SETUP, S_PULSE, S_HOLD,
    S_RD_SETUP, S_RD_WAIT, S_RD_CHECK, S_RD_FLOAT,
    S_VPP_DN, S_VCC_DN, S_FINISH
  } state_t;

  typedef enum { PH_PROG1, PH_VERIFY, PH_FINAL, PH_ID } phase_t;

  state_t state_q;
  phase_t phase_q;
  logic [TMR_W-1:0] tmr_q;
  logic [3:0] retry_q;
  logic fail_q;
  logic miss_q;
  logic [DATA_W-1:0] rd_sync;
  logic tmr_zero;

  assign tmr_zero = (tmr_q == '0);

  // Device data comes from pins, so sync it before comparing
  pin_sync #(.W(DATA_W)) u_rd_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(data_lines_in),
    .sync_out(rd_sync)
  );

  // ********************************************************
  // Main sequence
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      phase_q <= PH_PROG1;
      tmr_q <= '0;
      retry_q <= '0;
      fail_q <= 1'b0;
      miss_q <= 1'b0;
      rom_addr <= '0;
      src_addr <= '0;
      data_lines_out <= '0;
      data_lines_oe <= 1'b0;
      chip_sel_n <= 1'b1;
      out_drive_n <= 1'b1;
      core_supply <= SUP_OFF;
      prog_supply <= SUP_OFF;
      id_mode_address_pin <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      maker_code <= '0;
      device_code <= '0;
    end else begin
      done <= 1'b0;
      if (!tmr_zero) begin
        tmr_q <= tmr_q - 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (start) begin
            busy <= 1'b1;
            fail_q <= 1'b0;
            retry_q <= '0;
            rom_addr <= '0;
            src_addr <= '0;
            tmr_q <= TMR_W'(SETUP_CYC);
            phase_q <= (op == OP_READ_ID) ? PH_ID :
                       (op == OP_VERIFY) ? PH_FINAL : PH_PROG1;
            state_q <= S_VCC_UP;
          end
        end
        S_VCC_UP: begin
          // Core supply first, program supply only after setup
          core_supply <= (phase_q == PH_PROG1) ? SUP_PROG : SUP_NOM;
          if (tmr_zero) begin
            tmr_q <= TMR_W'(SETUP_CYC);
            state_q <= S_VPP_UP;
          end
        end
        S_VPP_UP: begin
          prog_supply <= (phase_q == PH_PROG1) ? SUP_PROG : SUP_NOM;
          id_mode_address_pin <= (phase_q == PH_ID);
          if (tmr_zero) begin
            tmr_q <= TMR_W'(SETUP_CYC);
            state_q <= (phase_q == PH_PROG1) ? S_SETUP : S_RD_SETUP;
          end
        end
        S_SETUP: begin
          // Drive data with output drive held off
          out_drive_n <= 1'b1;
          data_lines_oe <= 1'b1;
          data_lines_out <= src_data;
          if (tmr_zero) begin
            chip_sel_n <= 1'b0;
            tmr_q <= TMR_W'(PULSE_CYC);
            state_q <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (tmr_zero) begin
            chip_sel_n <= 1'b1;
            tmr_q <= TMR_W'(SETUP_CYC);
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (tmr_zero) begin
            data_lines_oe <= 1'b0;
            tmr_q <= TMR_W'(SETUP_CYC);
            if (phase_q == PH_PROG1) begin
              // No read back in the first pass
              if (rom_addr == LAST_ADDR) begin
                phase_q <= PH_VERIFY;
                rom_addr <= '0;
                src_addr <= '0;
                state_q <= S_RD_SETUP;
              end else begin
                rom_addr <= rom_addr + 1'b1;
                src_addr <= src_addr + 1'b1;
                state_q <= S_SETUP;
              end
            end else begin
              state_q <= S_RD_SETUP;
            end
          end
        end
        S_RD_SETUP: begin
          // Drivers released already; wait setup, then open output
          if (tmr_zero) begin
            out_drive_n <= 1'b0;
            chip_sel_n <= phase_q == PH_VERIFY ? 1'b1 : 1'b0;
            // Valid delay plus two sync stages
            tmr_q <= TMR_W'(OUT_VALID_CYC + 2);
            state_q <= S_RD_WAIT;
          end
        end
        S_RD_WAIT: begin
          if (tmr_zero) begin
            state_q <= S_RD_CHECK;
          end
        end
        S_RD_CHECK: begin
          out_drive_n <= 1'b1;
          chip_sel_n <= 1'b1;
          tmr_q <= TMR_W'(OUT_FLOAT_CYC);
          state_q <= S_RD_FLOAT;
          // Latch the compare now; the lines float right after
          miss_q <= (rd_sync != src_data);
          if (phase_q == PH_ID) begin
            if (rom_addr[0]) device_code <= rd_sync;
            else maker_code <= rd_sync;
          end else if (phase_q == PH_FINAL && rd_sync != src_data) begin
            fail_q <= 1'b1;
          end else if (phase_q == PH_VERIFY && rd_sync != src_data) begin
            if (retry_q == MAX_RETRY) begin
              fail_q <= 1'b1;
            end
          end
        end
        S_RD_FLOAT: begin
          if (tmr_zero) begin
            tmr_q <= TMR_W'(SETUP_CYC);
            if (phase_q == PH_VERIFY && fail_q) begin
              state_q <= S_VPP_DN;
            end else if (phase_q == PH_VERIFY && miss_q) begin
              retry_q <= retry_q + 1'b1;
              state_q <= S_SETUP;
            end else if (phase_q == PH_ID && !rom_addr[0]) begin
              rom_addr <= {{(ADDR_W-1){1'b0}}, 1'b1};
              state_q <= S_RD_SETUP;
            end else if (phase_q == PH_ID || rom_addr == LAST_ADDR) begin
              if (phase_q == PH_VERIFY) begin
                // Final phase set; S_VPP_DN sets the program supply nominal for one cycle, then off; no byte is read again
                phase_q <= PH_FINAL;
                rom_addr <= '0;
                src_addr <= '0;
                state_q <= S_VPP_DN;
              end else begin
                state_q <= S_VPP_DN;
              end
            end else begin
              retry_q <= '0;
              rom_addr <= rom_addr + 1'b1;
              src_addr <= src_addr + 1'b1;
              state_q <= S_RD_SETUP;
            end
          end
        end
        S_VPP_DN: begin
          // Program supply drops before the core supply
          id_mode_address_pin <= 1'b0;
          if (phase_q == PH_FINAL && !fail_q &&
              prog_supply == SUP_PROG) begin
            prog_supply <= SUP_NOM;
            if (tmr_zero) begin
              core_supply <= SUP_NOM;
              tmr_q <= TMR_W'(SETUP_CYC);
              state_q <= S_RD_SETUP;
            end
          end else begin
            prog_supply <= SUP_OFF;
            if (tmr_zero) begin
              tmr_q <= TMR_W'(SETUP_CYC);
              state_q <= S_VCC_DN;
            end
          end
        end
        S_VCC_DN: begin
          core_supply <= SUP_OFF;
          if (tmr_zero) begin
            state_q <= S_FINISH;
          end
        end
        S_FINISH: begin
          busy <= 1'b0;
          done <= 1'b1;
          pass <= !fail_q;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  int pw_cnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || chip_sel_n) pw_cnt <= 0;
    else pw_cnt <= pw_cnt + 1;
  end

  pulse_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(chip_sel_n) && data_lines_oe) |->
      ($past(pw_cnt) >= PULSE_MIN_US * 1000 / CLK_PERIOD_NS &&
       $past(pw_cnt) <= PULSE_MAX_US * 1000 / CLK_PERIOD_NS))
    else $error("program pulse width out of range");

  supply_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (prog_supply != SUP_OFF) |-> (core_supply != SUP_OFF))
    else $error("program supply on without core supply");

  drive_clash_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(data_lines_oe && !out_drive_n))
    else $error("output drive on while data driven");

  retry_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    retry_q <= MAX_RETRY)
    else $error("too many reprogram pulses");

  id_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    id_mode_address_pin |-> (phase_q == PH_ID))
    else $error("id pin raised outside id mode");

  read_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(out_drive_n) |-> out_drive_n == 1'b0 [*7])
    else $error("read sampled before output valid");

  fail_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (done && fail_q) |-> !pass)
    else $error("failed run reported as pass");

  start_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == S_IDLE && start) |=> rom_addr == '0)
    else $error("run did not start at first address");

  addr_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rom_addr != $past(rom_addr)) |->
      (rom_addr == $past(rom_addr) + 1'b1 || rom_addr == '0))
    else $error("address skipped or went backwards");

endmodule // otp_programmer

// *** sim/otp_device_model.sv ***
// Purpose: behavioural model of the 32K x 8 one-time-programmable memory
// Assumes: pins driven by the programmer under test
// Notes: data lines have no pull; unknown spans show moving data
`timescale 1ns/1ps
module otp_device_model
  import otp_prog_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary id value
  parameter logic [7:0] PART_ID = 8'hc3, // Arbitrary id value
  parameter int VALID_NS = OUT_VALID_NS
) (
  input wire logic [ADDR_W-1:0] rom_addr,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe,
  input wire logic chip_sel_n,
  input wire logic out_drive_n,
  input wire logic [1:0] prog_supply,
  input wire logic id_mode_address_pin,
  output logic [DATA_W-1:0] data_lines_in
);
  // ******************************************
  // Cell array
  // ******************************************
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

  // Blank cells read as all ones
  initial begin
    data_lines_in = 8'h00;
    foreach (cells[i]) cells[i] = 8'hff;
  end

  // Read path, id codes take over when the id pin is raised
  function automatic logic [DATA_W-1:0] fetch();
    if (id_mode_address_pin)
      return rom_addr[0] ? PART_ID : MAKER_ID;
    return cells[rom_addr];
  endfunction

  // Programming only clears bits, as a real fused cell would
  always @(posedge chip_sel_n) begin
    if (prog_supply == SUP_PROG && data_lines_oe) begin
      cells[rom_addr] = cells[rom_addr] & data_lines_out;
    end
  end

  // Data valid only after the output delay; junk before it
  always @(negedge out_drive_n) begin
    data_lines_in = ~data_lines_in;
    #(VALID_NS);
    if (!out_drive_n)
      data_lines_in = fetch();
  end

  // Lines float after the float delay, so stale data is not kept
  always @(posedge out_drive_n) begin
    #(OUT_FLOAT_NS);
    data_lines_in = ~data_lines_in;
  end
endmodule // otp_device_model

// *** sim/otp_programmer_tb_top.sv ***
// Purpose: self-checking bench for the memory programmer
// Assumes: device model on the pin side, random source bytes
// Notes: full program runs are too long; starts are checked then aborted
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  errors++; $display("CHECK FAILED at %0t: got %h expected %h", $time, \
  got, exp); end end
`define WAITC(c) begin n = 0; while ((c) !== 1'b1 && n < 20000) begin \
  @(negedge sys_clk); n++; end if ((c) !== 1'b1) begin errors++; \
  give_verdict(); end end
module otp_programmer_tb_top
  import otp_prog_pkg::*;
;
  // ******************************************
  // Signals and instances
  // ******************************************
  localparam logic [7:0] MAKER_ID = 8'h5a; // Arbitrary id value
  localparam logic [7:0] PART_ID = 8'hc3; // Arbitrary id value
  logic sys_clk, rst_n, start, data_lines_oe, chip_sel_n, out_drive_n;
  logic id_mode_address_pin, busy, done, pass;
  op_t op;
  logic [DATA_W-1:0] src_data, data_lines_in, data_lines_out;
  logic [DATA_W-1:0] maker_code, device_code;
  logic [ADDR_W-1:0] src_addr, rom_addr;
  logic [1:0] core_supply, prog_supply;
  logic [DATA_W-1:0] src_mem [0:32767];
  int errors, comparisons, n, reads;

  assign src_data = src_mem[src_addr];

  otp_programmer dut (.sys_clk(sys_clk), .rst_n(rst_n), .start(start),
    .op(op), .src_data(src_data), .src_addr(src_addr), .rom_addr(rom_addr),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .chip_sel_n(chip_sel_n),
    .out_drive_n(out_drive_n), .core_supply(core_supply),
    .prog_supply(prog_supply), .id_mode_address_pin(id_mode_address_pin),
    .busy(busy), .done(done), .pass(pass), .maker_code(maker_code),
    .device_code(device_code));

  otp_device_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) model (
    .rom_addr(rom_addr), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .chip_sel_n(chip_sel_n),
    .out_drive_n(out_drive_n), .prog_supply(prog_supply),
    .id_mode_address_pin(id_mode_address_pin),
    .data_lines_in(data_lines_in));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Reads seen on the pins, to prove the first pass skips them
  always @(negedge out_drive_n) reads++;

  // ******************************************
  // Tasks
  // ******************************************
  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
  endtask

  task automatic launch(input op_t o);
    start = 1'b1;
    op = o;
    @(negedge sys_clk);
    start = 1'b0;
  endtask

  // Counts cycles a low-active pin stays low, bounded
  task automatic low_len(input bit sel, output int len);
    len = 0;
    while ((sel ? out_drive_n : chip_sel_n) === 1'b0 && len < 5000) begin
      @(negedge sys_clk);
      len++;
    end
  endtask

  function automatic logic [7:0] expect_id(input bit low_bit);
    return low_bit ? PART_ID : MAKER_ID;
  endfunction

  // ******************************************
  // Main sequence
  // ******************************************
  initial begin
    int len;
    sys_clk = 1'b0;
    rst_n = 1'b0;
    start = 1'b0;
    op = OP_READ_ID;
    errors = 0;
    comparisons = 0;
    reads = 0;
    void'($urandom(32'he0ae));
    foreach (src_mem[i]) src_mem[i] = 8'($urandom);
    @(negedge sys_clk);
    do_reset();
    `CHK(chip_sel_n, 1'b1)
    `CHK(out_drive_n, 1'b1)
    `CHK(core_supply, SUP_OFF)
    `CHK(prog_supply, SUP_OFF)
    `CHK(pass, 1'b0)
    // Id runs back to back, a program request while busy is ignored
    repeat (3) begin
      launch(OP_READ_ID);
      `WAITC(id_mode_address_pin == 1'b1)
      `CHK(id_mode_address_pin, 1'b1)
      start = 1'b1;
      op = OP_PROGRAM;
      repeat (4) @(negedge sys_clk);
      start = 1'b0;
      // A taken program request would raise the core supply
      `CHK(core_supply, SUP_NOM)
      `WAITC(done == 1'b1)
      `CHK(maker_code, expect_id(1'b0))
      `CHK(device_code, expect_id(1'b1))
      repeat (2) @(negedge sys_clk);
      `CHK(busy, 1'b0)
      `CHK(id_mode_address_pin, 1'b0)
      `CHK(prog_supply, SUP_OFF)
    end
    // Program start: supplies in order, first two pulses, then abort
    launch(OP_PROGRAM);
    `WAITC(core_supply == SUP_PROG)
    `CHK(prog_supply == SUP_PROG, 1'b0)
    `CHK(rom_addr, 15'h0000)
    `WAITC(prog_supply == SUP_PROG)
    reads = 0;
    for (int a = 0; a < 2; a++) begin
      `WAITC(chip_sel_n == 1'b0)
      `CHK(rom_addr, a[ADDR_W-1:0])
      `CHK(data_lines_oe, 1'b1)
      `CHK(data_lines_out, src_mem[a])
      `CHK(out_drive_n, 1'b1)
      low_len(1'b0, len);
      // Timer reload, then one more edge ends the pulse
      `CHK(len, PULSE_CYC + 1)
    end
    `CHK(reads, 0)
    `CHK(core_supply, SUP_PROG)
    do_reset();
    `CHK(core_supply, SUP_OFF)
    `CHK(chip_sel_n, 1'b1)
    // Final-verify reads: nominal supplies, bus released, valid delay kept
    launch(OP_VERIFY);
    `WAITC(out_drive_n == 1'b0)
    `CHK(core_supply, SUP_NOM)
    `CHK(prog_supply, SUP_NOM)
    `CHK(data_lines_oe, 1'b0)
    low_len(1'b1, len);
    `CHK(len > OUT_VALID_CYC, 1'b1)
    `WAITC(out_drive_n == 1'b0)
    do_reset();
    // Reset in mid-read: output drive off, no result claimed
    `CHK(out_drive_n, 1'b1)
    `CHK(prog_supply, SUP_OFF)
    `CHK(pass, 1'b0)
    give_verdict();
  end
endmodule // otp_programmer_tb_top
